// >>> hw/aolp_pkg.sv
// package for the angle output latch port: register map, field positions,
// reset values, state codes and timing counts.
// assumes a 20 MHz core clock and a 14-bit left-aligned tracking counter.
`default_nettype none

package aolp_pkg;

  // angle word and pins
  localparam int ANGLE_W = 14;
  localparam int BYTE_W = 8;
  localparam int LOW_REM_W = 6;

  // clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int BUSY_MAX_NS = 1000;
  localparam int HOLD_SETUP_NS = 1000;
  // longest time rounds down
  localparam int BUSY_CYC = BUSY_MAX_NS / CLK_PERIOD_NS;
  // least time rounds up
  localparam int HOLD_SETUP_CYC =
    (HOLD_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 5;

  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_LATCH = 12'h008;
  localparam logic [11:0] OFS_TRACK = 12'h00C;
  localparam logic [11:0] OFS_UPD_CNT = 12'h010;
  localparam logic [11:0] OFS_FRZ_CNT = 12'h014;

  // ctrl fields
  localparam int CTRL_RES14 = 0;
  localparam int CTRL_SW_HOLD = 1;
  localparam logic CTRL_RES14_RST = 1'b1;
  localparam logic CTRL_SW_HOLD_RST = 1'b0;

  // status fields; bits 4..6 are sticky, write one to clear
  localparam int ST_BUSY = 0;
  localparam int ST_FROZEN = 1;
  localparam int ST_DRIVING = 2;
  localparam int ST_SETTLED = 3;
  localparam int ST_TORN = 4;
  localparam int ST_MISSED = 5;
  localparam int ST_EARLY = 6;
  localparam int ST_BYTE_SEL = 7;

  localparam int CNT_W = 16;

  // latch control states
  typedef enum logic [2:0] {
    AOLP_FOLLOW = 3'b001,
    AOLP_FROZEN = 3'b010,
    AOLP_RELOAD = 3'b100
  } aolp_state_t;

endpackage : aolp_pkg

`default_nettype wire

// >>> hw/aolp_lat_if.sv
// carrier between the latch core and the pin output stage.
// assumes both ends run on the same core clock.
`default_nettype none

interface aolp_lat_if;
  logic [13:0] word;
  logic res14;
  logic byte_hi;
  logic drive_n;
  logic [13:0] pin_out;
  logic [13:0] pin_oe_n;

  modport core (
    output word,
    output res14,
    output byte_hi,
    output drive_n,
    input pin_out,
    input pin_oe_n
  );

  modport stage (
    input word,
    input res14,
    input byte_hi,
    input drive_n,
    output pin_out,
    output pin_oe_n
  );
endinterface : aolp_lat_if

`default_nettype wire

// >>> hw/aolp_pin_stage.sv
// pin output stage: byte steering, zero fill and three-state enables.
// pin index 0 is data line one (angle msb); index 13 is data line 14.
`default_nettype none

module aolp_pin_stage (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // latch side
  aolp_lat_if.stage lat
);

  ////////////////////////////////////////////////////////////////////////////
  // one flop per pin keeps the pin data glitch free on byte changes
  for (genvar i = 0; i < aolp_pkg::ANGLE_W; i++) begin : g_pin
    logic next_bit;
    logic next_oe_n;

    // high half or full word, else the low remainder moved up, zero filled
    if (i < aolp_pkg::LOW_REM_W) begin : g_rem
      always_comb begin
        if (!lat.byte_hi) begin
          next_bit = lat.word[aolp_pkg::LOW_REM_W - 1 - i];
        end else begin
          next_bit = lat.word[aolp_pkg::ANGLE_W - 1 - i];
        end
      end
    end else if (i < aolp_pkg::BYTE_W) begin : g_fill
      always_comb begin
        if (!lat.byte_hi) begin
          next_bit = 1'b0;
        end else begin
          next_bit = lat.word[aolp_pkg::ANGLE_W - 1 - i];
        end
      end
    end else begin : g_full
      always_comb begin
        next_bit = lat.word[aolp_pkg::ANGLE_W - 1 - i];
      end
    end

    // 12-bit mode never drives the two lowest-weight lines
    if (i >= aolp_pkg::ANGLE_W - 2) begin : g_low2
      always_comb begin
        next_oe_n = lat.drive_n | ~lat.res14;
      end
    end else begin : g_up
      always_comb begin
        next_oe_n = lat.drive_n;
      end
    end

    // registered pin data and enable
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        lat.pin_out[i] <= 1'b0;
        lat.pin_oe_n[i] <= 1'b1;
      end else begin
        lat.pin_out[i] <= next_bit;
        lat.pin_oe_n[i] <= next_oe_n;
      end
    end
  end

endmodule : aolp_pin_stage

`default_nettype wire

// >>> hw/aolp_port.sv
// angle output latch port: latch, busy flag, three-state data pins, apb.
// assumes the tracking counter gives a 14-bit angle and a step pulse,
// and that all pins are synchronous to core_clk.
//
// Local design decisions: the register addresses and register access over APB.
`default_nettype none

module aolp_port (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // tracking counter
  input wire logic [13:0] trk_angle,
  input wire logic trk_step,
  // host control pins
  input wire logic hold_n,
  input wire logic out_en_n,
  input wire logic byte_half_select,
  // host data and busy pins
  output logic [13:0] data_out,
  output logic [13:0] data_oe_n,
  output logic busy,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  aolp_lat_if lat ();
  aolp_pkg::aolp_state_t state;
  aolp_pkg::aolp_state_t next_state;
  logic res14;
  logic sw_hold;
  logic [13:0] latch_word;
  logic [13:0] trk_masked;
  logic [aolp_pkg::TMR_W-1:0] busy_tmr;
  logic [aolp_pkg::TMR_W-1:0] setup_tmr;
  logic settled;
  logic hold_act;
  logic torn;
  logic missed;
  logic early;
  logic [aolp_pkg::CNT_W-1:0] upd_cnt;
  logic [aolp_pkg::CNT_W-1:0] frz_cnt;
  logic acc_wait;
  logic wr_done;
  logic [7:0] status_bits;
  logic [31:0] next_rdata;
  logic next_err;
  logic hit;

  ////////////////////////////////////////////////////////////////////////////
  // angle word: bit 13 is the msb (180 degrees), each next bit half of it;
  // in 12-bit mode the two lowest-weight bits read as zero
  always_comb begin
    trk_masked = trk_angle;
    if (!res14) begin
      trk_masked[1:0] = 2'h0;
    end
  end

  // the pin hold and the software hold both freeze the latch
  assign hold_act = ~hold_n | sw_hold;

  ////////////////////////////////////////////////////////////////////////////
  // latch control state
  always_comb begin
    case (state)
      aolp_pkg::AOLP_FOLLOW: begin
        if (hold_act) begin
          next_state = aolp_pkg::AOLP_FROZEN;
        end else begin
          next_state = aolp_pkg::AOLP_FOLLOW;
        end
      end
      aolp_pkg::AOLP_FROZEN: begin
        if (hold_act) begin
          next_state = aolp_pkg::AOLP_FROZEN;
        end else begin
          next_state = aolp_pkg::AOLP_RELOAD;
        end
      end
      aolp_pkg::AOLP_RELOAD: begin
        if (hold_act) begin
          next_state = aolp_pkg::AOLP_FROZEN;
        end else begin
          next_state = aolp_pkg::AOLP_FOLLOW;
        end
      end
      default: begin
        next_state = aolp_pkg::AOLP_FOLLOW;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= aolp_pkg::AOLP_FOLLOW;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output latch: loads every cycle unless frozen; the reload state also
  // loads, so a word released by hold is never a stale one
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      latch_word <= 14'h0000;
    end else if (state == aolp_pkg::AOLP_RELOAD) begin
      latch_word <= trk_masked;
    end else if (state == aolp_pkg::AOLP_FOLLOW && !hold_act) begin
      latch_word <= trk_masked;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // busy: retriggered by each counter step, so a fast-turning shaft keeps
  // it high; it keeps pulsing while the latch is frozen
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy_tmr <= '0;
    end else if (trk_step) begin
      busy_tmr <= aolp_pkg::TMR_W'(aolp_pkg::BUSY_CYC);
    end else if (busy_tmr != '0) begin
      busy_tmr <= busy_tmr - 1'b1;
    end
  end

  // busy pin registered, so it rises one edge before the pin data changes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= trk_step | (busy_tmr > 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hold setup timer: shows when a frozen word has stood long enough
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      setup_tmr <= '0;
    end else if (!hold_act) begin
      setup_tmr <= '0;
    end else if (!settled) begin
      setup_tmr <= setup_tmr + 1'b1;
    end
  end

  assign settled = setup_tmr >= aolp_pkg::TMR_W'(aolp_pkg::HOLD_SETUP_CYC);

  ////////////////////////////////////////////////////////////////////////////
  // sticky diagnostics; a new event in the clearing cycle wins
  // torn: output driven in follow mode while busy, the read is suspect
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      torn <= 1'b0;
    end else if (!out_en_n && !hold_act && busy) begin
      torn <= 1'b1;
    end else if (wr_done && paddr == aolp_pkg::OFS_STATUS &&
                 pwdata[aolp_pkg::ST_TORN]) begin
      torn <= 1'b0;
    end
  end

  // missed: counter stepped while the latch was frozen
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      missed <= 1'b0;
    end else if (trk_step && state == aolp_pkg::AOLP_FROZEN) begin
      missed <= 1'b1;
    end else if (wr_done && paddr == aolp_pkg::OFS_STATUS &&
                 pwdata[aolp_pkg::ST_MISSED]) begin
      missed <= 1'b0;
    end
  end

  // early: output enabled under hold before the setup time ran out
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      early <= 1'b0;
    end else if (!out_en_n && hold_act && !settled) begin
      early <= 1'b1;
    end else if (wr_done && paddr == aolp_pkg::OFS_STATUS &&
                 pwdata[aolp_pkg::ST_EARLY]) begin
      early <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // step counters, free running, wrap silently
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      upd_cnt <= '0;
    end else if (trk_step) begin
      upd_cnt <= upd_cnt + 1'b1;
    end
  end

  // steps that arrived while the latch was frozen
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      frz_cnt <= '0;
    end else if (trk_step && state == aolp_pkg::AOLP_FROZEN) begin
      frz_cnt <= frz_cnt + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin stage: steering and enables are registered there
  assign lat.word = latch_word;
  assign lat.res14 = res14;
  assign lat.byte_hi = byte_half_select;
  assign lat.drive_n = out_en_n;

  aolp_pin_stage u_pins (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .lat(lat.stage)
  );

  assign data_out = lat.pin_out;
  assign data_oe_n = lat.pin_oe_n;

  ////////////////////////////////////////////////////////////////////////////
  // apb: one wait state so read data comes from a flop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_wait <= 1'b0;
    end else begin
      acc_wait <= psel & penable & ~acc_wait;
    end
  end

  assign pready = acc_wait;
  assign wr_done = psel & penable & acc_wait & pwrite;

  // control register; resolution and the software hold are the only settings, so keep it simple
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      res14 <= aolp_pkg::CTRL_RES14_RST;
      sw_hold <= aolp_pkg::CTRL_SW_HOLD_RST;
    end else if (wr_done && paddr == aolp_pkg::OFS_CTRL) begin
      res14 <= pwdata[aolp_pkg::CTRL_RES14];
      sw_hold <= pwdata[aolp_pkg::CTRL_SW_HOLD];
    end
  end

  // status word
  always_comb begin
    status_bits = 8'h00;
    status_bits[aolp_pkg::ST_BUSY] = busy;
    status_bits[aolp_pkg::ST_FROZEN] = (state == aolp_pkg::AOLP_FROZEN);
    status_bits[aolp_pkg::ST_DRIVING] = ~out_en_n;
    status_bits[aolp_pkg::ST_SETTLED] = settled;
    status_bits[aolp_pkg::ST_TORN] = torn;
    status_bits[aolp_pkg::ST_MISSED] = missed;
    status_bits[aolp_pkg::ST_EARLY] = early;
    status_bits[aolp_pkg::ST_BYTE_SEL] = byte_half_select;
  end

  // address decode and read mux; unmapped offsets answer with an error
  always_comb begin
    next_rdata = 32'h0000_0000;
    hit = 1'b1;
    case (paddr)
      aolp_pkg::OFS_CTRL: begin
        next_rdata[aolp_pkg::CTRL_RES14] = res14;
        next_rdata[aolp_pkg::CTRL_SW_HOLD] = sw_hold;
      end
      aolp_pkg::OFS_STATUS: begin
        next_rdata[7:0] = status_bits;
      end
      aolp_pkg::OFS_LATCH: begin
        next_rdata[13:0] = latch_word;
      end
      aolp_pkg::OFS_TRACK: begin
        next_rdata[13:0] = trk_masked;
      end
      aolp_pkg::OFS_UPD_CNT: begin
        next_rdata[15:0] = upd_cnt;
      end
      aolp_pkg::OFS_FRZ_CNT: begin
        next_rdata[15:0] = frz_cnt;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    next_err = ~hit;
  end

  // read data and error captured in the first access cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !acc_wait) begin
      prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      pslverr <= next_err;
    end else begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

endmodule : aolp_port

`default_nettype wire

// >>> testbench/aolp_port_chk.sv
// checker: pin, busy and apb timing of the angle output latch port.
// assumes it is bound into aolp_port and sees only its ports.
`default_nettype none

module aolp_port_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // counter and host pins
  input wire logic [13:0] trk_angle,
  input wire logic trk_step,
  input wire logic hold_n,
  input wire logic out_en_n,
  input wire logic byte_half_select,
  input wire logic [13:0] data_out,
  input wire logic [13:0] data_oe_n,
  input wire logic busy,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ps;
  // three cycles of margin over the designed busy length
  localparam int QUIET_MIN = 23;
  logic [13:0] trk_d1;
  logic [13:0] trk_d2;
  logic [13:0] rev_d2;
  logic [4:0] quiet;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // counter delayed by load edge plus pin register, lines flipped
  always_ff @(posedge core_clk) begin
    trk_d1 <= trk_angle;
    trk_d2 <= trk_d1;
  end
  always_comb begin
    for (int i = 0; i < 14; i++) begin
      rev_d2[i] = trk_d2[13 - i];
    end
  end
  // cycles since the last step; saturates so it never wraps
  always_ff @(posedge core_clk) begin
    if (!rst_n || trk_step) begin
      quiet <= 5'h00;
    end else if (quiet != 5'h1F) begin
      quiet <= quiet + 5'h01;
    end
  end

  ////////////////////////////////////////
  a_busy_rise: assert property (trk_step |=> busy[*8])
    else $error("busy not raised by a step");
  a_busy_fall: assert property (quiet >= QUIET_MIN |-> !busy)
    else $error("busy still high after quiet time");
  a_pins_driven: assert property (
    $past(!out_en_n) |-> data_oe_n[11:0] == 12'h000)
    else $error("data pins not driven");
  a_pins_float: assert property (
    $past(out_en_n) |-> data_oe_n == 14'h3FFF)
    else $error("data pins not released");
  a_hold_freeze: assert property (
    !hold_n[*3] ##0 $stable({byte_half_select, out_en_n})
    |=> $stable(data_out))
    else $error("data changed while held");
  a_follow_word: assert property (
    $past(hold_n, 2) && $past(hold_n, 3) && $past(byte_half_select)
    && !data_oe_n[13]
    && $past(!data_oe_n[13]) |-> data_out == rev_d2)
    else $error("data does not follow counter");
  a_low_zero: assert property (
    !$past(byte_half_select) |-> data_out[7:6] == 2'b00)
    else $error("low half not zero filled");
  a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
    else $error("apb answer not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");

  c_freeze: cover property (!hold_n[*3] ##1 !out_en_n);
  c_busy_end: cover property ($fell(busy));
  c_slverr: cover property (pslverr);
endmodule : aolp_port_chk

bind aolp_port aolp_port_chk i_chk (
  .core_clk, .rst_n, .trk_angle, .trk_step, .hold_n, .out_en_n,
  .byte_half_select, .data_out, .data_oe_n, .busy, .psel, .penable,
  .pready, .pslverr
);

`default_nettype wire

// >>> testbench/aolp_host_model.sv
// host model: drives hold, enable and byte select, reads the bus.
// assumes it shares core_clk with the port.
`default_nettype none

module aolp_host_model (
  // clock
  input wire logic core_clk,
  // control pins
  output logic hold_n,
  output logic out_en_n,
  output logic byte_half_select,
  // data and busy pins
  input wire logic [13:0] data_out,
  input wire logic [13:0] data_oe_n,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] last = 14'h0000;
  // a released line must not look driven, so it flips every cycle
  wire [13:0] bus = (data_oe_n & ~last) | (~data_oe_n & data_out);

  always_ff @(posedge core_clk) begin
    last <= bus;
  end
  initial begin
    hold_n = 1'b1;
    out_en_n = 1'b1;
    byte_half_select = 1'b1; // pad pull-up, select left open
  end

  // freeze, wait the setup time, read both halves, then release
  task automatic sync_read(input int slow, output logic [13:0] hi,
                           output logic [7:0] lo);
    @(posedge core_clk);
    hold_n <= 1'b0;
    repeat (aolp_pkg::HOLD_SETUP_CYC + slow) @(posedge core_clk);
    out_en_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    hi = bus;
    byte_half_select <= 1'b0;
    repeat (2) @(posedge core_clk);
    lo = bus[7:0];
    byte_half_select <= 1'b1;
    out_en_n <= 1'b1;
    hold_n <= 1'b1;
    @(posedge core_clk);
  endtask : sync_read

  // read with hold high; any busy seen spoils the word
  task automatic async_read(output logic [13:0] w, output logic spoilt);
    spoilt = 1'b0;
    @(posedge core_clk);
    out_en_n <= 1'b0;
    repeat (3) begin
      @(posedge core_clk);
      spoilt = spoilt | busy;
    end
    w = bus;
    out_en_n <= 1'b1;
    @(posedge core_clk);
  endtask : async_read
endmodule : aolp_host_model

`default_nettype wire

// >>> testbench/angle_output_latch_port_tb.sv
// testbench: apb tasks, counter stimulus and a host model on the pins.
// assumes a 20 MHz core clock and the port's one-wait-state apb.
`default_nettype none

`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module angle_output_latch_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [13:0] trk_angle = 14'h0000;
  logic trk_step = 1'b0;
  logic hold_n, out_en_n, byte_half_select, busy, pready, pslverr;
  logic [13:0] data_out, data_oe_n;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, q;
  logic [13:0] w, hi;
  logic [7:0] lo;
  logic err, spoilt;
  logic mode12 = 1'b0;
  int fails = 0;
  int n_tests = 0;
  int cnt;

  always #25 core_clk = ~core_clk;

  aolp_port i_dut (.core_clk, .rst_n, .trk_angle, .trk_step, .hold_n,
    .out_en_n, .byte_half_select, .data_out, .data_oe_n, .busy, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr);
  aolp_host_model i_host (.core_clk, .hold_n, .out_en_n,
    .byte_half_select, .data_out, .data_oe_n, .busy);

  ////////////////////////////////////////
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic step_to(input logic [13:0] a);
    @(posedge core_clk);
    trk_angle <= a;
    trk_step <= 1'b1;
    @(posedge core_clk);
    trk_step <= 1'b0;
  endtask : step_to

  // bounded wait for busy low; cnt tells how long it stayed high
  task automatic quiet_wait();
    cnt = 0;
    while (busy !== 1'b0 && cnt < 40) begin
      @(posedge core_clk);
      cnt++;
    end
  endtask : quiet_wait

  function automatic logic [13:0] rev(input logic [13:0] x);
    rev = {<<{x}};
  endfunction : rev

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // in 12-bit mode the two lowest lines are never driven
  always @(posedge core_clk) begin
    if (mode12) begin
      `CHK(data_oe_n[13:12], 2'b11)
    end
  end

  // the run needs about 200 cycles
  initial begin
    repeat (5000) @(posedge core_clk);
    fails++;
    wrap_up();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    `CHK(data_oe_n, 14'h3FFF)
    `CHK(busy, 1'b0)
    apb(1'b0, aolp_pkg::OFS_CTRL, 32'h00000000, q, err);
    `CHK(q, 32'h00000001)
    // unmapped offset answers with an error and zero data
    apb(1'b0, 12'h020, 32'h00000000, q, err);
    `CHK({err, q}, 33'h100000000)
    apb(1'b1, 12'h020, 32'h00000000, q, err);
    `CHK(err, 1'b1)
    // a step raises busy, which drops after the quiet time
    step_to(14'h2A5C);
    @(posedge core_clk);
    `CHK(busy, 1'b1)
    quiet_wait();
    `CHK(cnt inside {[18:21]}, 1'b1)
    // hold high: the pins follow the counter, msb on line one
    i_host.async_read(w, spoilt);
    `CHK(w, rev(14'h2A5C))
    `CHK(spoilt, 1'b0)
    @(posedge core_clk);
    `CHK(data_oe_n, 14'h3FFF)
    // a step in mid-read shows up as busy
    fork
      i_host.async_read(w, spoilt);
      step_to(14'h1234);
    join
    `CHK(spoilt, 1'b1)
    quiet_wait();
    // hold freezes the word while the counter keeps moving
    fork
      i_host.sync_read(0, hi, lo);
      begin
        repeat (4) @(posedge core_clk);
        step_to(14'h0F0F);
      end
    join
    w = rev(14'h1234);
    `CHK(hi, w)
    `CHK(lo, {2'b00, w[13:8]})
    // the torn read and the frozen step leave their sticky marks
    apb(1'b0, aolp_pkg::OFS_STATUS, 32'h00000000, q, err);
    `CHK(q, 32'h000000B0)
    apb(1'b1, aolp_pkg::OFS_STATUS, 32'h00000070, q, err);
    apb(1'b0, aolp_pkg::OFS_STATUS, 32'h00000000, q, err);
    `CHK(q, 32'h00000080)
    // the counter kept stepping while the latch was frozen
    apb(1'b0, aolp_pkg::OFS_UPD_CNT, 32'h00000000, q, err);
    `CHK(q, 32'h00000003)
    apb(1'b0, aolp_pkg::OFS_FRZ_CNT, 32'h00000000, q, err);
    `CHK(q, 32'h00000001)
    apb(1'b0, aolp_pkg::OFS_TRACK, 32'h00000000, q, err);
    `CHK(q, 32'h00000F0F)
    quiet_wait();
    i_host.async_read(w, spoilt);
    `CHK(w, rev(14'h0F0F))
    apb(1'b0, aolp_pkg::OFS_LATCH, 32'h00000000, q, err);
    `CHK(q, 32'h00000F0F)
    // 12-bit mode with a slow host: low bits cleared, lines 5-8 zero
    apb(1'b1, aolp_pkg::OFS_CTRL, 32'h00000000, q, err);
    mode12 = 1'b1;
    step_to(14'h3FFF);
    quiet_wait();
    i_host.sync_read(7, hi, lo);
    `CHK(hi[11:0], 12'hFFF)
    `CHK(lo, 8'h0F)
    mode12 = 1'b0;
    apb(1'b1, aolp_pkg::OFS_CTRL, 32'h00000001, q, err);
    // the software hold freezes the latch just as the pin does
    apb(1'b1, aolp_pkg::OFS_CTRL, 32'h00000003, q, err);
    step_to(14'h0555);
    apb(1'b0, aolp_pkg::OFS_LATCH, 32'h00000000, q, err);
    `CHK(q, 32'h00003FFF)
    apb(1'b1, aolp_pkg::OFS_CTRL, 32'h00000001, q, err);
    apb(1'b0, aolp_pkg::OFS_LATCH, 32'h00000000, q, err);
    `CHK(q, 32'h00000555)
    // a reset in mid-run returns pins and settings to idle
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    `CHK({data_oe_n, busy}, 15'h7FFE)
    apb(1'b0, aolp_pkg::OFS_CTRL, 32'h00000000, q, err);
    `CHK(q, 32'h00000001)
    wrap_up();
  end
endmodule : angle_output_latch_port_tb

`default_nettype wire
